// ### sim/cet_bus_model.sv
// Model of the bus targets that the CPU cycles reach
`timescale 1ns/100ps
module cet_bus_model (
  // Target selects
  input  wire logic [2:0]           code_sel_i,
  input  wire logic [2:0]           data_sel_i,
  input  wire logic [3:0]           waits_i,
  // Target conditions
  output      cet_pkg::cet_target_t code_tgt_o,
  output      cet_pkg::cet_target_t data_tgt_o
);
  // Select 0 memory, 1/2 module 8/16, 3/4 ext 8-bit 2/3 state, 5/6 ext 16-bit
  function automatic cet_pkg::cet_target_t pick(input logic [2:0] s);
    cet_pkg::cet_target_t t;
    t.region = s == 3'h0 ? cet_pkg::CET_REG_ONCHIP_MEM :
               s < 3'h3 ? cet_pkg::CET_REG_ONCHIP_MOD : cet_pkg::CET_REG_EXTERNAL;
    t.width  = cet_pkg::cet_width_t'(s == 3'h2 || s > 3'h4);
    t.style  = cet_pkg::cet_style_t'(s == 3'h4 || s == 3'h6);
    t.waits  = waits_i;
    return t;
  endfunction
  assign code_tgt_o = pick(code_sel_i);
  assign data_tgt_o = pick(data_sel_i);
endmodule // cet_bus_model

// ### sim/cet_exec_timer_bench.sv
// Self-checking bench for the execution state calculator
`timescale 1ns/100ps
module cet_exec_timer_bench;
  // Selects, waits, counts {N,M,L,K,J,I}, total, fetch cost, word cost
  typedef struct packed {
    logic [2:0] cs, ds; logic [3:0] m; logic [47:0] c; logic [19:0] st; logic [5:0] fc, wc;
  } cet_row_t;
  cet_row_t rows [10] = '{
    '{3'h0, 3'h0, 4'h0, 48'h020101000003, 20'h00007, 6'h01, 6'h01},
    '{3'h6, 3'h1, 4'h1, 48'h000002000002, 20'h0000C, 6'h04, 6'h04},
    '{3'h6, 3'h1, 4'h1, 48'h000000020202, 20'h00018, 6'h04, 6'h04},
    '{3'h2, 3'h2, 4'h0, 48'h030101000001, 20'h00009, 6'h02, 6'h02},
    '{3'h3, 3'h3, 4'h0, 48'h000101000002, 20'h0000E, 6'h04, 6'h04},
    '{3'h4, 3'h4, 4'h2, 48'h010101000101, 20'h00024, 6'h0A, 6'h0A},
    '{3'h5, 3'h5, 4'h7, 48'h000101010001, 20'h00008, 6'h02, 6'h02},
    '{3'h6, 3'h6, 4'hF, 48'hC80101000001, 20'h000FE, 6'h12, 6'h12},
    '{3'h4, 3'h0, 4'hF, 48'h0000000000FF, 20'h023DC, 6'h24, 6'h01},
    '{3'h1, 3'h4, 4'h1, 48'h000000010101, 20'h00010, 6'h04, 6'h08}};
  cet_row_t             nrow = '{3'h4, 3'h4, 4'h2, 48'h050000000000, 20'h00005, 6'h0A, 6'h0A};
  logic                 core_clk, reset_n, req_valid, req_ready, done;
  logic [2:0]           cs, ds;
  logic [3:0]           m;
  logic [47:0]          cnt;
  logic [19:0]          exec_states;
  logic [5:0]           fetch_cost, word_cost;
  cet_pkg::cet_target_t ct, dt;
  cet_pkg::cet_req_t    req;
  int                   error_cnt, n_checks;
  // Code and branch reads use the code target, stack and data the data target
  assign req = {cnt, ct, dt, dt};
  cet_bus_model bus_u (.code_sel_i(cs), .data_sel_i(ds), .waits_i(m), .code_tgt_o(ct), .data_tgt_o(dt));
  cet_exec_timer dut_u (.core_clk_i(core_clk), .reset_n_i(reset_n), .req_valid_i(req_valid), .req_i(req),
    .req_ready_o(req_ready), .done_o(done), .exec_states_o(exec_states), .fetch_cost_o(fetch_cost),
    .word_cost_o(word_cost));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Present a row at the falling edge; returns one cycle later
  task drive(input cet_row_t r);
    cs = r.cs; ds = r.ds; m = r.m; cnt = r.c; req_valid = 1'b1;
    @(negedge core_clk);
  endtask
  task exp_row(input cet_row_t r);
    chk(done, 20'h00001); chk(exec_states, r.st); chk(fetch_cost, r.fc); chk(word_cost, r.wc);
  endtask
  initial begin
    req_valid = 1'b0; cs = 3'h0; ds = 3'h0; m = 4'h0; cnt = '0; reset_n = 1'b0; error_cnt = 0; n_checks = 0;
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk); chk(req_ready, 20'h00000);
    @(negedge core_clk); chk(req_ready, 20'h00001);
    $display("reset release done");
    foreach (rows[i]) begin
      drive(rows[i]); req_valid = 1'b0;
      exp_row(rows[i]);
      @(negedge core_clk); chk(done, 20'h00000);
      $display("row %0d done", i);
    end
    // Back to back requests, the last one internal cycles only
    drive(rows[1]); exp_row(rows[1]);
    drive(rows[5]); exp_row(rows[5]);
    drive(nrow); req_valid = 1'b0; exp_row(nrow);
    @(negedge core_clk); chk(done, 20'h00000); chk(exec_states, 20'h00005);
    $display("back to back done");
    // Reset in mid run clears at once, ready returns on the second edge
    reset_n = 1'b0; #1;
    chk(done, 20'h00000); chk(exec_states, 20'h00000); chk(req_ready, 20'h00000);
    @(negedge core_clk); reset_n = 1'b1;
    @(negedge core_clk); chk(req_ready, 20'h00000);
    @(negedge core_clk); chk(req_ready, 20'h00001);
    drive(rows[0]); req_valid = 1'b0; exp_row(rows[0]);
    $display("reset done");
    final_report;
  end
  initial begin
    #20000;
    error_cnt++;
    final_report;
  end
endmodule // cet_exec_timer_bench

// ### sim/cet_exec_timer_checker.sv
// Port assertions for the execution state calculator
`timescale 1ns/100ps
module cet_exec_timer_checker #(
  parameter int CNT_W = 8, parameter int COST_W = 6, parameter int ACC_W = 20
) (
  input wire logic              core_clk_i,
  input wire logic              reset_n_i,
  input wire logic              req_valid_i,
  input wire cet_pkg::cet_req_t req_i,
  input wire logic              req_ready_o,
  input wire logic              done_o,
  input wire logic [ACC_W-1:0]  exec_states_o,
  input wire logic [COST_W-1:0] fetch_cost_o,
  input wire logic [COST_W-1:0] word_cost_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Taken request and its targets
  logic                 tk;
  cet_pkg::cet_target_t ct, dt;
  assign tk = req_valid_i && req_ready_o;
  assign ct = req_i.code_tgt;
  assign dt = req_i.data_tgt;
  a_done_take: assert property (tk |=> done_o) else $error("done missing");
  a_done_only: assert property (!tk |=> !done_o) else $error("done without request");
  a_result_hold: assert property (!tk |=> $stable(exec_states_o)) else $error("total moved");
  a_mem_fetch: assert property (tk && ct.region == cet_pkg::CET_REG_ONCHIP_MEM |=> fetch_cost_o == 6'h01)
    else $error("memory fetch cost");
  a_mod_fetch: assert property (tk && ct.region == cet_pkg::CET_REG_ONCHIP_MOD
    |=> fetch_cost_o == ($past(ct.width) ? 6'h02 : 6'h04)) else $error("module fetch cost");
  a_ext8_word: assert property (tk && dt.region == cet_pkg::CET_REG_EXTERNAL && !dt.width && dt.style
    |=> word_cost_o == 6'h06 + 2 * $past(dt.waits)) else $error("external word cost");
  a_ext16_fetch: assert property (tk && ct.region == cet_pkg::CET_REG_EXTERNAL && ct.width
    |=> fetch_cost_o == ($past(ct.style) ? 6'h03 + $past(ct.waits) : 6'h02)) else $error("wide fetch cost");
  a_internal_one: assert property (tk && req_i.cnt[4:0] == 0
    |=> exec_states_o == $past(req_i.cnt[5])) else $error("internal cost");
  a_fetch_sum: assert property (tk && req_i.cnt[5:1] == 0
    |=> exec_states_o == $past(req_i.cnt[0]) * fetch_cost_o) else $error("total wrong");
endmodule // cet_exec_timer_checker
bind cet_exec_timer cet_exec_timer_checker #(.CNT_W(CNT_W), .COST_W(COST_W), .ACC_W(ACC_W)) chk_u (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
  .req_ready_o(req_ready_o), .done_o(done_o), .exec_states_o(exec_states_o),
  .fetch_cost_o(fetch_cost_o), .word_cost_o(word_cost_o));

// ### verilog/cet_exec_timer.sv
// Instruction execution state calculator built from per-cycle costs
`timescale 1ns/100ps
`include "cet_params.svh"

module cet_exec_timer #(
  parameter int CNT_W  = `CET_CNT_W,   // Width of one cycle count
  parameter int COST_W = `CET_COST_W,  // Width of one per-cycle cost
  parameter int ACC_W  = `CET_ACC_W    // Width of the total
) (
  // Clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                reset_n_i,
  // Request
  input  wire logic                req_valid_i,
  input  wire cet_pkg::cet_req_t   req_i,
  output      logic                req_ready_o,
  // Result
  output      logic                done_o,
  output      logic [ACC_W-1:0]    exec_states_o,
  output      logic [COST_W-1:0]   fetch_cost_o,
  output      logic [COST_W-1:0]   word_cost_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser
  ////////////////////////////////////////////////////////////////////////////

  logic rst_meta_r;  // First stage, read only by the second
  logic rst_n_r;     // Synchronised reset used by the design

  // Asynchronous assert, synchronous release
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // Both stages drop at once with the pin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      // Release ripples through two stages so no flop sees a metastable edge
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-cycle cost
  ////////////////////////////////////////////////////////////////////////////

  // States taken by one cycle of the given kind on the given target
  // A cost depends only on the kind and on where the cycle goes
  // Branch reads and stack operations take the word figures
  function automatic logic [COST_W-1:0] cycle_cost(
    input cet_pkg::cet_kind_t   kind,
    input cet_pkg::cet_target_t tgt
  );
    logic [COST_W-1:0] m_c;    // Wait states
    logic [COST_W-1:0] m2_c;   // Twice the wait states
    logic              byte_c; // Byte-wide data access
    logic              fetch_c; // Instruction fetch
    // Wait-state terms widened to the cost width; 6 + 2m peaks at 36
    m_c     = COST_W'(tgt.waits);
    m2_c    = COST_W'({tgt.waits, 1'b0});
    byte_c  = (kind == cet_pkg::CET_KIND_BYTE);
    fetch_c = (kind == cet_pkg::CET_KIND_FETCH);
    // Branch reads and stack operations fall through as word accesses
    cycle_cost = `CET_COST_ONE;
    if (kind == cet_pkg::CET_KIND_INTERNAL) begin
      // Internal operation ignores the bus
      cycle_cost = `CET_COST_ONE;
    end else begin
      unique case (tgt.region)
        // On-chip memory answers in one state
        cet_pkg::CET_REG_ONCHIP_MEM: begin
          cycle_cost = `CET_COST_ONE;
        end
        // On-chip supporting modules, two states per bus access
        cet_pkg::CET_REG_ONCHIP_MOD: begin
          if (tgt.width == cet_pkg::CET_BUS_16) begin
            cycle_cost = `CET_COST_TWO;
          end else if (byte_c) begin
            cycle_cost = `CET_COST_TWO;
          end else begin
            cycle_cost = `CET_COST_FOUR;
          end
        end
        // External devices
        cet_pkg::CET_REG_EXTERNAL: begin
          if (tgt.width == cet_pkg::CET_BUS_16) begin
            // Sixteen-bit bus: one access per fetch or word
            if (tgt.style == cet_pkg::CET_ACC_2STATE) begin
              cycle_cost = `CET_COST_TWO;
            end else begin
              cycle_cost = COST_W'(`CET_COST_THREE + m_c);
            end
          end else if (tgt.style == cet_pkg::CET_ACC_2STATE) begin
            // Eight-bit bus, two-state access
            cycle_cost = byte_c ? `CET_COST_TWO : `CET_COST_FOUR;
          end else if (byte_c) begin
            // Eight-bit bus, three-state byte
            cycle_cost = COST_W'(`CET_COST_THREE + m_c);
          end else begin
            // Eight-bit bus, three-state word or fetch takes two accesses
            cycle_cost = COST_W'(`CET_COST_SIX + m2_c);
          end
        end
        // Unused region code costs one state
        default: begin
          cycle_cost = `CET_COST_ONE;
        end
      endcase
    end
    // Keep fetch recognisable for readers; it shares the word path
    if (fetch_c && tgt.region == cet_pkg::CET_REG_ONCHIP_MEM) begin
      cycle_cost = `CET_COST_ONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Target selection and sum of products
  ////////////////////////////////////////////////////////////////////////////

  // Which target a cycle of a kind uses
  // Branch reads come from the code area; internal cycles touch no bus
  function automatic cet_pkg::cet_target_t pick_target(
    input cet_pkg::cet_kind_t kind,
    input cet_pkg::cet_req_t  req
  );
    unique case (kind)
      cet_pkg::CET_KIND_FETCH:     pick_target = req.code_tgt;
      cet_pkg::CET_KIND_BRANCH_RD: pick_target = req.code_tgt;
      cet_pkg::CET_KIND_STACK:     pick_target = req.stack_tgt;
      cet_pkg::CET_KIND_BYTE:      pick_target = req.data_tgt;
      cet_pkg::CET_KIND_WORD:      pick_target = req.data_tgt;
      cet_pkg::CET_KIND_INTERNAL:  pick_target = req.data_tgt;
      default:                     pick_target = req.data_tgt;
    endcase
  endfunction

  logic [ACC_W-1:0]  sum_nxt;        // Total for the request on the inputs
  logic [COST_W-1:0] fetch_cost_nxt; // Fetch cost for the request
  logic [COST_W-1:0] word_cost_nxt;  // Word cost for the request

  // Weigh each kind's count by its cost and add them up
  // 255 cycles of every kind at 36 states each still fit the total's width
  always_comb begin
    cet_pkg::cet_kind_t kind_c; // Kind being weighed
    logic [COST_W-1:0]  cost_c; // Its cost on its target
    logic [CNT_W-1:0]   cnt_c;  // Its count
    // Defaults first so that no path leaves a variable unassigned
    kind_c  = cet_pkg::CET_KIND_FETCH;
    cost_c  = `CET_COST_ONE;
    cnt_c   = '0;
    sum_nxt = `CET_ACC_RST;
    for (int k = 0; k < `CET_KIND_NUM; k++) begin
      kind_c  = cet_pkg::cet_kind_t'(k[2:0]);
      cost_c  = cycle_cost(kind_c, pick_target(kind_c, req_i));
      cnt_c   = CNT_W'(req_i.cnt[k]);
      sum_nxt = ACC_W'(sum_nxt + ACC_W'(cnt_c) * ACC_W'(cost_c));
    end
    // Two single costs that the result also shows on their own
    fetch_cost_nxt = cycle_cost(cet_pkg::CET_KIND_FETCH, req_i.code_tgt);
    word_cost_nxt  = cycle_cost(cet_pkg::CET_KIND_WORD, req_i.data_tgt);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handshake and result registers
  ////////////////////////////////////////////////////////////////////////////

  // Ready whenever out of reset; one request per cycle
  // The sum settles within one cycle, so there is never back pressure
  // A request on an edge where reset is still held is simply dropped
  assign req_ready_o = rst_n_r;

  // Result registers, one for each output
  logic              done_r;        // A request was taken on the last edge
  logic [ACC_W-1:0]  exec_states_r; // Total states of the last request
  logic [COST_W-1:0] fetch_cost_r;  // Fetch cost on its code target
  logic [COST_W-1:0] word_cost_r;   // Word cost on its data target

  // Done pulses one cycle after an accepted request
  always_ff @(posedge core_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      // Nothing is taken while ready is low
      done_r <= 1'b0;
    end else begin
      // Ready is high here, so valid alone means taken
      done_r <= req_valid_i;
    end
  end

  // Result holds until the next accepted request
  always_ff @(posedge core_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      // Cleared while the block is held in reset
      exec_states_r <= `CET_ACC_RST;
      fetch_cost_r  <= '0;
      word_cost_r   <= '0;
    end else if (req_valid_i) begin
      // Load the figures worked out for the request just taken
      exec_states_r <= sum_nxt;
      fetch_cost_r  <= fetch_cost_nxt;
      word_cost_r   <= word_cost_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  ////////////////////////////////////////////////////////////////////////////

  // Every output comes straight from a flip-flop, ready from the second synchroniser stage
  assign done_o        = done_r;
  assign exec_states_o = exec_states_r;
  assign fetch_cost_o  = fetch_cost_r;
  assign word_cost_o   = word_cost_r;

endmodule // cet_exec_timer

// ### verilog/cet_params.svh
// Named constants for the CPU execution state timing block
`ifndef CET_PARAMS_SVH
`define CET_PARAMS_SVH

// Field widths shared by the package and the module
`define CET_CNT_W        8
`define CET_WAIT_W       4
`define CET_COST_W       6
`define CET_ACC_W        20
`define CET_KIND_NUM     6

// Per-cycle state costs
`define CET_COST_ONE     6'h01
`define CET_COST_TWO     6'h02
`define CET_COST_THREE   6'h03
`define CET_COST_FOUR    6'h04
`define CET_COST_SIX     6'h06

// Reset values
`define CET_ACC_RST      20'h00000

`endif

// ### verilog/cet_pkg.sv
// Types for the CPU execution state timing block
`include "cet_params.svh"

package cet_pkg;

  // Six kinds of cycle, in the order of the count vector
  typedef enum logic [2:0] {
    CET_KIND_FETCH,
    CET_KIND_BRANCH_RD,
    CET_KIND_STACK,
    CET_KIND_BYTE,
    CET_KIND_WORD,
    CET_KIND_INTERNAL
  } cet_kind_t;

  // Where a cycle goes
  typedef enum logic [1:0] {
    CET_REG_ONCHIP_MEM,
    CET_REG_ONCHIP_MOD,
    CET_REG_EXTERNAL
  } cet_region_t;

  // Bus width of a target
  typedef enum logic {
    CET_BUS_8,
    CET_BUS_16
  } cet_width_t;

  // Access style of an external target
  typedef enum logic {
    CET_ACC_2STATE,
    CET_ACC_3STATE
  } cet_style_t;

  // One target's access conditions
  typedef struct packed {
    cet_region_t                region;
    cet_width_t                 width;
    cet_style_t                 style;
    logic [`CET_WAIT_W-1:0]     waits;
  } cet_target_t;

  // One instruction's cycle counts and the targets of its cycles
  typedef struct packed {
    logic [`CET_KIND_NUM-1:0][`CET_CNT_W-1:0] cnt;
    cet_target_t                code_tgt;
    cet_target_t                stack_tgt;
    cet_target_t                data_tgt;
  } cet_req_t;

endpackage
